// File: rtl/dsn_pkg.sv
package dsn_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_INSTR    = 8'h04;
  localparam logic [7:0]  OFF_DSR      = 8'h08;
  localparam logic [7:0]  OFF_MAC_HI   = 8'h0c;
  localparam logic [7:0]  OFF_MACL     = 8'h10;
  localparam logic [7:0]  OFF_STATUS   = 8'h14;
  localparam logic [7:0]  OFF_REG_BASE = 8'h40;
  localparam logic [7:0]  OFF_GRD_BASE = 8'h80;

  // ----------------------------------------------------------------
  // Status register fields and reset values
  // ----------------------------------------------------------------
  localparam int          DSR_COND = 0;
  localparam int          DSR_N   = 1;
  localparam int          DSR_Z   = 2;
  localparam int          DSR_V   = 3;
  localparam int          DSR_GRTR = 4;
  localparam int          DSR_CS0 = 5;
  localparam logic [31:0] DSR_RST = 32'h0000_0000;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [7:0]  GRD_RST = 8'h00;
  localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Opcode prefixes of the second instruction word
  // ----------------------------------------------------------------
  localparam logic [5:0]  PFX_DSP      = 6'h3e;
  localparam logic [11:0] OP_LDS_HI    = 12'hed0;
  localparam logic [11:0] OP_LDS_LO    = 12'hfd0;
  localparam logic [11:0] OP_LDS_HI_T  = 12'hee0;
  localparam logic [11:0] OP_LDS_LO_T  = 12'hfe0;
  localparam logic [11:0] OP_LDS_HI_F  = 12'hef0;
  localparam logic [11:0] OP_LDS_LO_F  = 12'hff0;
  localparam logic [7:0]  OP_NEG_X     = 8'hc9;
  localparam logic [7:0]  OP_NEG_X_T   = 8'hca;
  localparam logic [7:0]  OP_NEG_X_F   = 8'hcb;
  localparam logic [7:0]  OP_NEG_Y     = 8'he9;
  localparam logic [7:0]  OP_NEG_Y_T   = 8'hea;
  localparam logic [7:0]  OP_NEG_Y_F   = 8'heb;
  localparam logic [3:0]  OP_FMUL      = 4'h4;

  // ----------------------------------------------------------------
  // Register file indices
  // ----------------------------------------------------------------
  localparam logic [3:0]  IDX_A0 = 4'h0;
  localparam logic [3:0]  IDX_A1 = 4'h1;
  localparam logic [3:0]  IDX_M0 = 4'h2;
  localparam logic [3:0]  IDX_M1 = 4'h3;
  localparam logic [3:0]  IDX_X0 = 4'h4;
  localparam logic [3:0]  IDX_X1 = 4'h5;
  localparam logic [3:0]  IDX_Y0 = 4'h6;
  localparam logic [3:0]  IDX_Y1 = 4'h7;
  localparam int          NREG   = 8;
  localparam logic [7:0]  GUARD_ONES = 8'hff;
  localparam logic [7:0]  GUARD_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [1:0]  PAR_EXTRA_CYC = 2'h1;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_HOLD} dsn_state_t;

endpackage

// File: rtl/dsn_neg_unit.sv
`timescale 1ns/1ps
module dsn_neg_unit (
  // Operand
  input  wire logic [39:0] src,
  // Result and flags
  output logic [39:0]      res,
  output logic             neg_f,
  output logic             zero_f,
  output logic             ovf_f,
  output logic             grtr_f,
  output logic             carry_f
);
  wire logic [40:0] diff;
  assign diff    = {1'b0, 40'h00_0000_0000} - {1'b0, src};
  assign res     = diff[39:0];
  assign neg_f   = diff[39];
  assign zero_f  = (diff[39:0] == 40'h00_0000_0000);
  assign ovf_f   = src[39] & diff[39];
  assign grtr_f  = ~diff[39] & ~zero_f;
  assign carry_f = diff[40];
endmodule

// File: rtl/dsn_frac_mul.sv
`timescale 1ns/1ps
module dsn_frac_mul (
  // Factors
  input  wire logic [15:0] fa,
  input  wire logic [15:0] fb,
  // Product
  output logic [39:0]      prod
);
  wire logic signed [31:0] p;
  wire logic [31:0]        frac;
  assign p    = $signed(fa) * $signed(fb);
  assign frac = {p[30:0], 1'b0};
  assign prod = {{8{frac[31]}}, frac};
endmodule

// File: rtl/dsn_dsp_exec.sv
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - An unconditional system load copies the selected register into the multiply-acc high or low register.
// - Conditional system loads copy only when the condition flag is set (true form) or clear (false form).
// - No system load changes the condition, negative, zero, overflow or greater-than bits.
// - A system load paired with a parallel store or data move takes two cycles.
// - The fractional multiply multiplies upper words as signed, writes the destination, keeps flags.
// - The fractional result differs from the integer signed multiply of the same operands.
// - Negate subtracts the X-side or Y-side source from zero into the destination, 40 bits for A0/A1, low 32 bits for the others.
// - Conditional negates execute only on a matching condition flag, otherwise nothing changes.
// - An unconditional negate updates N, Z, V, greater-than and the condition flag per the select field.
// - A conditional negate that executes leaves all five status flags untouched.
// - Y-side select codes 0 to 3 choose Y0, Y1, M0, M1.
// - A Y-side negate operand gets guard bits by sign extension.
// - An accumulator negate operand uses its own guard byte.
module dsn_dsp_exec (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0]          regs_reg [dsn_pkg::NREG];
  logic [7:0]           grd_reg [2];
  logic [31:0]          dsr_reg;
  logic [31:0]          mac_hi_reg;
  logic [31:0]          macl_reg;
  logic [31:0]          instr_reg;
  logic                 par_reg;
  logic                 busy_reg;
  logic                 done_reg;
  logic [1:0]           wait_reg;
  dsn_pkg::dsn_state_t  state_reg;
  logic                 aw_hold_reg;
  logic                 w_hold_reg;
  logic [7:0]           awaddr_reg;
  logic [31:0]          wdata_reg;
  logic [3:0]           wstrb_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] map_xy(input logic y, input logic [1:0] c);
    if (y)
      map_xy = (c == 2'h0) ? dsn_pkg::IDX_Y0 : (c == 2'h1) ? dsn_pkg::IDX_Y1 :
               (c == 2'h2) ? dsn_pkg::IDX_M0 : dsn_pkg::IDX_M1;
    else
      map_xy = (c == 2'h0) ? dsn_pkg::IDX_X0 : (c == 2'h1) ? dsn_pkg::IDX_X1 :
               (c == 2'h2) ? dsn_pkg::IDX_A0 : dsn_pkg::IDX_A1;
  endfunction

  wire logic [15:0] op;
  wire logic        pfx_ok;
  wire logic        cond_flag;
  wire logic        is_lds;
  wire logic        lds_hi;
  wire logic        lds_go;
  wire logic        is_neg;
  wire logic        neg_y;
  wire logic        neg_unc;
  wire logic        neg_go;
  wire logic        is_mul;
  wire logic [3:0]  dest_sel;
  wire logic [3:0]  nsrc;
  wire logic [39:0] nop40;
  wire logic [39:0] nres;
  wire logic        f_n;
  wire logic        f_z;
  wire logic        f_v;
  wire logic        f_grtr;
  wire logic        f_c;
  wire logic        dc_new;
  wire logic [39:0] mprod;
  wire logic [3:0]  mdst;
  wire logic [3:0]  mfa;
  wire logic [3:0]  mfb;

  assign op      = instr_reg[15:0];
  assign pfx_ok  = (instr_reg[31:26] == dsn_pkg::PFX_DSP);
  assign cond_flag = dsr_reg[dsn_pkg::DSR_COND];
  assign dest_sel  = op[3:0];
  assign lds_hi  = (op[15:4] == dsn_pkg::OP_LDS_HI) | (op[15:4] == dsn_pkg::OP_LDS_HI_T) |
                   (op[15:4] == dsn_pkg::OP_LDS_HI_F);
  assign is_lds  = pfx_ok & (lds_hi | (op[15:4] == dsn_pkg::OP_LDS_LO) |
                   (op[15:4] == dsn_pkg::OP_LDS_LO_T) | (op[15:4] == dsn_pkg::OP_LDS_LO_F));
  assign lds_go  = is_lds & ((op[9:8] == 2'h1) | (op[9:8] == 2'h2 & cond_flag) |
                   (op[9:8] == 2'h3 & ~cond_flag)) & (dest_sel < 4'(dsn_pkg::NREG));
  assign neg_y   = (op[15:8] == dsn_pkg::OP_NEG_Y) | (op[15:8] == dsn_pkg::OP_NEG_Y_T) |
                   (op[15:8] == dsn_pkg::OP_NEG_Y_F);
  assign is_neg  = pfx_ok & (neg_y | (op[15:8] == dsn_pkg::OP_NEG_X) |
                   (op[15:8] == dsn_pkg::OP_NEG_X_T) | (op[15:8] == dsn_pkg::OP_NEG_X_F));
  assign neg_unc = (op[9:8] == 2'h1);
  assign neg_go  = is_neg & (neg_unc | (op[9:8] == 2'h2 & cond_flag) |
                   (op[9:8] == 2'h3 & ~cond_flag)) & (dest_sel < 4'(dsn_pkg::NREG));
  assign nsrc    = neg_y ? map_xy(1'b1, op[5:4]) : map_xy(1'b0, op[7:6]);
  assign nop40   = (nsrc == dsn_pkg::IDX_A0) ? {grd_reg[0], regs_reg[0]} :
                   (nsrc == dsn_pkg::IDX_A1) ? {grd_reg[1], regs_reg[1]} :
                   {(regs_reg[nsrc[2:0]][31] ? dsn_pkg::GUARD_ONES : dsn_pkg::GUARD_ZERO),
                    regs_reg[nsrc[2:0]]};
  assign is_mul  = pfx_ok & (op[15:12] == dsn_pkg::OP_FMUL) & (op[7:4] == 4'h0) & (op[1:0] == 2'h0);
  assign mfa     = map_xy(1'b0, {1'b0, op[11]} + 2'h0) ^ {3'h0, op[10]};
  assign mfb     = op[9] ? (op[8] ? dsn_pkg::IDX_M1 : dsn_pkg::IDX_M0) : (op[8] ? dsn_pkg::IDX_Y1 : dsn_pkg::IDX_Y0);
  assign mdst    = op[3] ? (op[2] ? dsn_pkg::IDX_A1 : dsn_pkg::IDX_A0) : (op[2] ? dsn_pkg::IDX_M1 : dsn_pkg::IDX_M0);

  dsn_neg_unit u_neg (
    .src     (nop40),
    .res     (nres),
    .neg_f   (f_n),
    .zero_f  (f_z),
    .ovf_f   (f_v),
    .grtr_f  (f_grtr),
    .carry_f (f_c)
  );

  dsn_frac_mul u_mul (
    .fa   (regs_reg[mfa[2:0]][31:16]),
    .fb   (regs_reg[mfb[2:0]][31:16]),
    .prod (mprod)
  );

  // Condition flag per the 3-bit select field.
  wire logic [2:0] cs;
  assign cs     = dsr_reg[dsn_pkg::DSR_CS0 +: 3];
  assign dc_new = (cs == 3'h0) ? f_c : (cs == 3'h1) ? f_n : (cs == 3'h2) ? f_z : (cs == 3'h3) ? f_v :
                  (cs == 3'h4) ? f_grtr : (cs == 3'h5) ? ~f_n : 1'b0;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic        wr_go;
  wire logic        rd_go;
  wire logic [7:0]  rd_a;
  wire logic        wr_instr;
  wire logic [31:0] wmask;
  wire logic [31:0] rd_data;
  wire logic        rd_ok;
  wire logic        wr_ok;
  assign wr_go    = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  assign rd_go    = s_axi_arvalid & s_axi_arready;
  assign rd_a     = s_axi_araddr;
  assign wmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_instr = wr_go & (awaddr_reg == dsn_pkg::OFF_INSTR) & ~busy_reg;
  assign wr_ok    = (awaddr_reg == dsn_pkg::OFF_INSTR) | (awaddr_reg == dsn_pkg::OFF_CTRL) |
                    (awaddr_reg == dsn_pkg::OFF_DSR) | (awaddr_reg[7:5] == 3'h2) |
                    ((awaddr_reg[7:3] == 5'h10) & (awaddr_reg[1:0] == 2'h0));
  assign rd_ok    = (rd_a[1:0] == 2'h0) & ((rd_a <= dsn_pkg::OFF_STATUS) | (rd_a[7:5] == 3'h2) | (rd_a[7:3] == 5'h10));
  assign rd_data  = (rd_a == dsn_pkg::OFF_INSTR) ? instr_reg :
                    (rd_a == dsn_pkg::OFF_CTRL) ? {31'h0, par_reg} :
                    (rd_a == dsn_pkg::OFF_DSR) ? dsr_reg :
                    (rd_a == dsn_pkg::OFF_MAC_HI) ? mac_hi_reg :
                    (rd_a == dsn_pkg::OFF_MACL) ? macl_reg :
                    (rd_a == dsn_pkg::OFF_STATUS) ? {30'h0, done_reg, busy_reg} :
                    (rd_a[7:5] == 3'h2) ? regs_reg[rd_a[4:2]] :
                    (rd_a[7:3] == 5'h10) ? {24'h0, grd_reg[rd_a[2]]} : dsn_pkg::BUS_ERR_DATA;

  // ----------------------------------------------------------------
  // Execution sequencer
  // ----------------------------------------------------------------
  wire logic exec_now;
  assign exec_now = (state_reg == dsn_pkg::ST_EXEC) & (wait_reg == 2'h0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= dsn_pkg::ST_IDLE;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      wait_reg  <= 2'h0;
    end
    else if (ce)
    begin
      case (state_reg)
        dsn_pkg::ST_IDLE:
        begin
          if (wr_instr)
          begin
            state_reg <= dsn_pkg::ST_EXEC;
            busy_reg  <= 1'b1;
            done_reg  <= 1'b0;
            wait_reg  <= (par_reg & (wdata_reg[31:26] == dsn_pkg::PFX_DSP)) ? dsn_pkg::PAR_EXTRA_CYC : 2'h0;
          end
        end
        dsn_pkg::ST_EXEC:
        begin
          if (wait_reg != 2'h0)
            wait_reg <= wait_reg - 2'h1;
          else
            state_reg <= dsn_pkg::ST_HOLD;
        end
        default:
        begin
          state_reg <= dsn_pkg::ST_IDLE;
          busy_reg  <= 1'b0;
          done_reg  <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file and status
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < dsn_pkg::NREG; gi++)
    begin : g_reg
      wire logic [3:0] idx = 4'(gi);
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          regs_reg[gi] <= dsn_pkg::REG_RST;
        else if (ce)
        begin
          if (exec_now & neg_go & (dest_sel == idx))
            regs_reg[gi] <= nres[31:0];
          else if (exec_now & is_mul & (mdst == idx))
            regs_reg[gi] <= mprod[31:0];
          else if (wr_go & ~busy_reg & (awaddr_reg == dsn_pkg::OFF_REG_BASE + 8'(4 * gi)))
            regs_reg[gi] <= (regs_reg[gi] & ~wmask) | (wdata_reg & wmask);
        end
      end
      if (gi < 2)
      begin : g_grd
        always_ff @(posedge aclk)
        begin
          if (!aresetn)
            grd_reg[gi] <= dsn_pkg::GRD_RST;
          else if (ce)
          begin
            if (exec_now & neg_go & (dest_sel == idx))
              grd_reg[gi] <= nres[39:32];
            else if (exec_now & is_mul & (mdst == idx))
              grd_reg[gi] <= mprod[39:32];
            else if (wr_go & ~busy_reg & (awaddr_reg == dsn_pkg::OFF_GRD_BASE + 8'(4 * gi)) & wstrb_reg[0])
              grd_reg[gi] <= wdata_reg[7:0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dsr_reg  <= dsn_pkg::DSR_RST;
      mac_hi_reg <= dsn_pkg::REG_RST;
      macl_reg <= dsn_pkg::REG_RST;
      instr_reg <= dsn_pkg::REG_RST;
      par_reg  <= 1'b0;
    end
    else if (ce)
    begin
      if (exec_now & lds_go & lds_hi)
        mac_hi_reg <= regs_reg[dest_sel[2:0]];
      if (exec_now & lds_go & ~lds_hi)
        macl_reg <= regs_reg[dest_sel[2:0]];
      if (exec_now & neg_go & neg_unc)
        dsr_reg[4:0] <= {f_grtr, f_v, f_z, f_n, dc_new};
      else if (wr_go & ~busy_reg & (awaddr_reg == dsn_pkg::OFF_DSR))
        dsr_reg <= {24'h0, (dsr_reg[7:0] & ~wmask[7:0]) | (wdata_reg[7:0] & wmask[7:0])};
      if (wr_instr)
        instr_reg <= wdata_reg;
      if (wr_go & (awaddr_reg == dsn_pkg::OFF_CTRL) & wstrb_reg[0])
        par_reg <= wdata_reg[0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0000_0000;
    end
    else if (ce)
    begin
      s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_hold_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_ok & ~busy_reg) ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_data : dsn_pkg::BUS_ERR_DATA;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_lds_flags_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce & exec_now & is_lds) |=> (dsr_reg[4:0] == $past(dsr_reg[4:0])))
    else $error("System load changed status flags.");
  a_lds_hi_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce & exec_now & lds_go & lds_hi) |=> (mac_hi_reg == $past(regs_reg[dest_sel[2:0]])))
    else $error("High load did not copy source.");
  a_lds_skip_nop: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce & exec_now & is_lds & ~lds_go) |=> ($stable(mac_hi_reg) & $stable(macl_reg)))
    else $error("Failed condition still loaded.");
  a_mul_flags_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce & exec_now & is_mul) |=> $stable(dsr_reg))
    else $error("Multiply changed status.");
  a_mul_frac_lsb: assert property (@(posedge aclk) disable iff (!aresetn)
    is_mul |-> (mprod[0] == 1'b0) & (mprod[39:32] == {8{mprod[31]}}))
    else $error("Fraction product misformed.");
  a_neg_cond_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce & exec_now & is_neg & ~neg_unc) |=> $stable(dsr_reg[4:0]))
    else $error("Conditional negate changed flags.");
  a_neg_zero_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce & exec_now & neg_go & neg_unc & (nop40 == 40'h00_0000_0000)) |=> dsr_reg[dsn_pkg::DSR_Z])
    else $error("Zero flag not set.");
  a_neg_sum_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    is_neg |-> ((nres + nop40) == 40'h00_0000_0000))
    else $error("Negate result wrong.");
  a_neg_y_guard: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_neg & neg_y) |-> (nop40[39:32] == {8{nop40[31]}}))
    else $error("Y operand guard not extended.");
  a_two_cycle_par: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce & wr_instr & par_reg & (wdata_reg[31:26] == dsn_pkg::PFX_DSP) & (state_reg == dsn_pkg::ST_IDLE))
    |=> (ce & ~exec_now) [*1])
    else $error("Paired load executed early.");

endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd;
  int          err_count    = 0;
  int          total_checks = 0;

  always #2 aclk = ~aclk;

  dsn_dsp_exec i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    rs = bresp;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask

  function automatic logic [7:0] ra(input logic [3:0] i);
    return dsn_pkg::OFF_REG_BASE + {2'b00, i, 2'b00};
  endfunction

  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk(what, exp, rd);
  endtask

  task automatic run(input logic [15:0] w);
    axw(dsn_pkg::OFF_INSTR, {dsn_pkg::PFX_DSP, 10'h000, w});
    do
    begin
      axr(dsn_pkg::OFF_STATUS);
    end
    while (rd[1] !== 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_load;
    axw(dsn_pkg::OFF_DSR, 32'h0);
    chk("dsr bresp", 32'h0, {30'h0, rs});
    axw(ra(dsn_pkg::IDX_X0), 32'h1234_5678);
    axw(ra(dsn_pkg::IDX_X1), 32'hcafe_0001);
    run({dsn_pkg::OP_LDS_HI, dsn_pkg::IDX_X0});
    rc("mac_hi", dsn_pkg::OFF_MAC_HI, 32'h1234_5678);
    run({dsn_pkg::OP_LDS_LO, dsn_pkg::IDX_X1});
    rc("macl", dsn_pkg::OFF_MACL, 32'hcafe_0001);
    run({dsn_pkg::OP_LDS_HI_T, dsn_pkg::IDX_X1});
    rc("mac_hi", dsn_pkg::OFF_MAC_HI, 32'h1234_5678);
    run({dsn_pkg::OP_LDS_LO_F, dsn_pkg::IDX_X0});
    rc("macl", dsn_pkg::OFF_MACL, 32'h1234_5678);
    axw(dsn_pkg::OFF_DSR, 32'h1);
    run({dsn_pkg::OP_LDS_HI_F, dsn_pkg::IDX_X1});
    rc("mac_hi", dsn_pkg::OFF_MAC_HI, 32'h1234_5678);
    axw(dsn_pkg::OFF_CTRL, 32'h1);
    run({dsn_pkg::OP_LDS_LO_T, dsn_pkg::IDX_X1});
    rc("macl", dsn_pkg::OFF_MACL, 32'hcafe_0001);
    axw(dsn_pkg::OFF_CTRL, 32'h0);
    rc("dsr", dsn_pkg::OFF_DSR, 32'h1);
  endtask

  task automatic t_mul;
    axw(dsn_pkg::OFF_DSR, 32'h15);
    axw(ra(dsn_pkg::IDX_X0), 32'h0001_0000);
    axw(ra(dsn_pkg::IDX_Y0), 32'h0002_0000);
    axw(ra(dsn_pkg::IDX_M0), 32'h3333_3333);
    run(16'h4000);
    rc("m0", ra(dsn_pkg::IDX_M0), 32'h0000_0004);
    axw(ra(dsn_pkg::IDX_X1), 32'hfffe_2222);
    axw(ra(dsn_pkg::IDX_Y1), 32'h0001_aaaa);
    axw(ra(dsn_pkg::IDX_A0), 32'h4444_4444);
    run(16'h4508);
    rc("a0", ra(dsn_pkg::IDX_A0), 32'hffff_fffc);
    rc("a0 guard", dsn_pkg::OFF_GRD_BASE, 32'h0000_00ff);
    rc("dsr", dsn_pkg::OFF_DSR, 32'h15);
  endtask

  task automatic t_neg;
    axw(dsn_pkg::OFF_DSR, 32'h20);
    axw(ra(dsn_pkg::IDX_X0), 32'h5555_5555);
    run({dsn_pkg::OP_NEG_X, 4'h0, dsn_pkg::IDX_A0});
    rc("a0", ra(dsn_pkg::IDX_A0), 32'haaaa_aaab);
    rc("a0 guard", dsn_pkg::OFF_GRD_BASE, 32'h0000_00ff);
    rc("dsr", dsn_pkg::OFF_DSR, 32'h23);
    axw(dsn_pkg::OFF_GRD_BASE, 32'h0);
    run({dsn_pkg::OP_NEG_X, 4'h8, dsn_pkg::IDX_A1});
    rc("a1", ra(dsn_pkg::IDX_A1), 32'h5555_5555);
    rc("a1 guard", 8'h84, 32'h0000_00ff);
    axw(dsn_pkg::OFF_DSR, 32'h20);
    axw(ra(dsn_pkg::IDX_Y1), 32'h9999_9999);
    run({dsn_pkg::OP_NEG_Y, 4'h1, dsn_pkg::IDX_A1});
    rc("a1", ra(dsn_pkg::IDX_A1), 32'h6666_6667);
    rc("a1 guard", 8'h84, 32'h0);
    rc("dsr", dsn_pkg::OFF_DSR, 32'h30);
    run({dsn_pkg::OP_NEG_Y, 4'h2, dsn_pkg::IDX_X0});
    rc("x0", ra(dsn_pkg::IDX_X0), 32'hffff_fffc);
    axw(dsn_pkg::OFF_DSR, 32'h0);
    axw(ra(dsn_pkg::IDX_X0), 32'h1);
    axw(ra(dsn_pkg::IDX_X1), 32'h0);
    run({dsn_pkg::OP_NEG_X_T, 4'h0, dsn_pkg::IDX_X1});
    rc("x1", ra(dsn_pkg::IDX_X1), 32'h0);
    run({dsn_pkg::OP_NEG_X_F, 4'h0, dsn_pkg::IDX_X1});
    rc("x1", ra(dsn_pkg::IDX_X1), 32'hffff_ffff);
    rc("dsr", dsn_pkg::OFF_DSR, 32'h0);
    axw(dsn_pkg::OFF_DSR, 32'h1);
    run({dsn_pkg::OP_NEG_Y_F, 4'h0, dsn_pkg::IDX_Y1});
    rc("y1", ra(dsn_pkg::IDX_Y1), 32'h9999_9999);
    run({dsn_pkg::OP_NEG_Y_T, 4'h0, dsn_pkg::IDX_Y1});
    rc("y1", ra(dsn_pkg::IDX_Y1), 32'hfffe_0000);
    rc("dsr", dsn_pkg::OFF_DSR, 32'h1);
    axr(8'h3c);
    chk("unmapped resp", 32'h2, {30'h0, rs});
    axw(8'h3c, 32'h0);
    chk("unmapped bresp", 32'h2, {30'h0, rs});
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_load;
    t_mul;
    t_neg;
    tally_and_finish;
  end

  initial
  begin
    #200000;
    err_count++;
    tally_and_finish;
  end
endmodule
